/* pkg/brw_map.svh */
/*
  register offsets, field positions, reset values and widths of the
  burst rom wait controller. assumes inclusion by bare name only.
*/
`ifndef BRW_MAP_SVH
`define BRW_MAP_SVH
// ----------------------------------------------------------------
// register word offsets (avalon word addresses)
// ----------------------------------------------------------------
`define BRW_ADDR_W        4
`define BRW_CTRL_OFS      4'h0
`define BRW_STAT_OFS      4'h1
// ----------------------------------------------------------------
// wait control register fields
// ----------------------------------------------------------------
`define BRW_BW_MSB        17
`define BRW_BW_LSB        16
`define BRW_W_MSB         10
`define BRW_W_LSB         7
`define BRW_WM_BIT        6
`define BRW_CTRL_MASK     32'h0003_07C0
`define BRW_CTRL_RESET    32'h0000_0500
// ----------------------------------------------------------------
// wait counting
// ----------------------------------------------------------------
`define BRW_CNT_W         5
`define BRW_W_FIRST_RSVD  4'hD
`define BRW_W_RSVD_CLAMP  5'h18
`endif

/* pkg/brw_pkg.sv */
/*
  types and decode helpers of the burst rom wait controller.
  assumes brw_map.svh on the include path.
*/
`include "brw_map.svh"
package brw_pkg;
  // access sequencer states, one-hot
  typedef enum logic [3:0] {
    BRW_IDLE  = 4'b0001,
    BRW_FIRST = 4'b0010,
    BRW_BEAT  = 4'b0100,
    BRW_GAP   = 4'b1000
  } brw_state_t;

  typedef logic [`BRW_CNT_W-1:0] brw_cnt_t;

  // first-access wait code to cycle count; reserved codes clamp to the longest
  function automatic brw_cnt_t brw_first_wait(input logic [3:0] code);
    brw_cnt_t n;
    n = `BRW_W_RSVD_CLAMP;
    unique case (code)
      4'h7:    n = 5'h08;
      4'h8:    n = 5'h0A;
      4'h9:    n = 5'h0C;
      4'hA:    n = 5'h0E;
      4'hB:    n = 5'h12;
      4'hC:    n = 5'h18;
      4'hD, 4'hE, 4'hF: n = `BRW_W_RSVD_CLAMP;
      default: n = {1'b0, code};
    endcase
    return n;
  endfunction : brw_first_wait
endpackage : brw_pkg

/* pkg/brw_wait_if.sv */
/*
  carrier between the access sequencer and its wait counter.
  assumes both ends run on the same clk.
*/
`timescale 1ns/10ps
interface brw_wait_if;
  logic               ce;        // global clock enable
  logic               tick;      // one rom clock rising edge seen
  logic               load;      // reload the counter
  logic               hold;      // honoured external wait
  brw_pkg::brw_cnt_t  load_val;  // cycles to wait
  brw_pkg::brw_cnt_t  remain;    // cycles still to wait
  logic               done;      // wait over on this tick
  modport ctl (output ce, tick, load, hold, load_val, input remain, done);
  modport cnt (input ce, tick, load, hold, load_val, output remain, done);
endinterface : brw_wait_if

/* rtl/brw_top.sv */
/*
  wait control for a clock synchronous burst rom on area 0: register
  over avalon-mm, first-access and burst wait insertion, external wait.
  assumes rom clock, wait and data pins come from outside the clk domain.
*/
// Local design decisions: register access over Avalon-MM and the register offsets.
//
// Overview of operation
// - burst beats separated by 0 to 3 waits
// - first access waits 0-6,8,10,12,14,18,24
// - mask bit 0 honours wait pin, 1 ignores
// - mask applies even with zero first wait
// - reserved register bits read zero, written zero
`timescale 1ns/10ps
`include "brw_map.svh"
module brw_top #(
  parameter int DATA_W  = 16,  // rom data width
  parameter int LEN_W   = 4    // burst length width
) (
  // clock, reset, enable
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              ce,
  // avalon-mm slave
  input  wire logic [`BRW_ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [3:0]        byteenable,
  input  wire logic [31:0]       writedata,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // access request side
  input  wire logic              acc_start,
  input  wire logic [LEN_W-1:0]  acc_len,
  output logic                   acc_busy,
  output logic                   acc_done,
  output logic                   beat_valid,
  output logic      [DATA_W-1:0] beat_data,
  // rom pins
  input  wire logic              rom_clk,
  input  wire logic              rom_wait_n,
  input  wire logic [DATA_W-1:0] rom_data,
  output logic                   rom_cs_n,
  output logic                   rom_oe_n
);
  // elaboration guard: status word holds 8 count bits, data lanes 32
  if (DATA_W < 1 || DATA_W > 32 || LEN_W < 1 || LEN_W > 8) begin : g_bad_param
    $error("brw_top: unsupported DATA_W or LEN_W");
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic              clk_s1, clk_s2, clk_s3;  // rom clock samples
  logic              wait_s1, wait_s2;        // wait pin, active low
  logic [DATA_W-1:0] dat_s1, dat_s2;          // rom data

  // two flops per pin; the third clock flop only finds the edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {clk_s1, clk_s2, clk_s3} <= 3'h0;
      {wait_s1, wait_s2}       <= 2'h3;
      dat_s1 <= '0;
      dat_s2 <= '0;
    end else if (ce) begin
      {clk_s1, clk_s2, clk_s3} <= {rom_clk, clk_s1, clk_s2};
      {wait_s1, wait_s2}       <= {rom_wait_n, wait_s1};
      dat_s1 <= rom_data;
      dat_s2 <= dat_s1;
    end
  end

  // ----------------------------------------------------------------
  // wait control register
  // ----------------------------------------------------------------
  logic [1:0] bw_code;   // burst wait field
  logic [3:0] w_code;    // first-access wait field
  logic       ext_wait_mask;

  wire        sel_ctrl = (address == `BRW_CTRL_OFS);
  wire        sel_stat = (address == `BRW_STAT_OFS);
  wire        wr_take  = ce && write && !waitrequest && sel_ctrl;
  wire [31:0] ctrl_val = {14'h0, bw_code, 5'h00, w_code, ext_wait_mask, 6'h00};
  wire        w_rsvd   = (w_code >= `BRW_W_FIRST_RSVD);

  // byte lane 2 carries the burst field, lanes 0 and 1 the rest
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bw_code       <= 2'h0;
      w_code        <= 4'hA;
      ext_wait_mask <= 1'b0;
    end else if (wr_take) begin
      if (byteenable[2]) bw_code <= writedata[`BRW_BW_MSB:`BRW_BW_LSB];
      if (byteenable[1]) w_code[3:1] <= writedata[`BRW_W_MSB:`BRW_W_LSB+1];
      if (byteenable[0]) begin
        w_code[0]     <= writedata[`BRW_W_LSB];
        ext_wait_mask <= writedata[`BRW_WM_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  brw_pkg::brw_state_t state, next_state;
  logic [LEN_W-1:0]    beats_left;  // beats still to capture
  brw_wait_if          wif ();

  wire tick      = ce && clk_s2 && !clk_s3;          // rom clock rising edge
  wire honour    = !ext_wait_mask && !wait_s2;
  wire last_beat = (beats_left <= LEN_W'(1));
  wire start_ok  = acc_start && (acc_len != '0) && (state == brw_pkg::BRW_IDLE);
  wire beat_take = (state == brw_pkg::BRW_BEAT) && tick;
  wire gap_go    = beat_take && !last_beat && (bw_code != 2'h0);

  assign wif.ce       = ce;
  assign wif.tick     = tick;
  assign wif.hold     = honour;
  assign wif.load     = start_ok || gap_go;
  assign wif.load_val = start_ok ? brw_pkg::brw_first_wait(w_code)
                                 : {3'h0, bw_code} - 5'h01;

  brw_waitgen u_wait (
    .clk    (clk),
    .arst_n (arst_n),
    .w      (wif)
  );

  // next state; a zero burst wait keeps streaming beats
  always_comb begin
    next_state = state;
    unique case (state)
      brw_pkg::BRW_IDLE:  if (start_ok) next_state = brw_pkg::BRW_FIRST;
      brw_pkg::BRW_FIRST: if (wif.done) next_state = brw_pkg::BRW_BEAT;
      brw_pkg::BRW_GAP:   if (wif.done) next_state = brw_pkg::BRW_BEAT;
      brw_pkg::BRW_BEAT: begin
        if (beat_take && last_beat) next_state = brw_pkg::BRW_IDLE;
        else if (gap_go)            next_state = brw_pkg::BRW_GAP;
      end
      default:                      next_state = brw_pkg::BRW_IDLE;
    endcase
  end

  // state and beat bookkeeping
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= brw_pkg::BRW_IDLE;
      beats_left <= '0;
    end else if (ce) begin
      state <= next_state;
      if (start_ok)       beats_left <= acc_len;
      else if (beat_take) beats_left <= beats_left - LEN_W'(1);
    end
  end

  // pins and user outputs, all registered
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rom_cs_n   <= 1'b1;
      rom_oe_n   <= 1'b1;
      acc_busy   <= 1'b0;
      acc_done   <= 1'b0;
      beat_valid <= 1'b0;
      beat_data  <= '0;
    end else if (ce) begin
      rom_cs_n   <= (next_state == brw_pkg::BRW_IDLE);
      rom_oe_n   <= (next_state == brw_pkg::BRW_IDLE);
      acc_busy   <= (next_state != brw_pkg::BRW_IDLE);
      acc_done   <= beat_take && last_beat;
      beat_valid <= beat_take;
      if (beat_take) beat_data <= dat_s2;
    end
  end

  // ----------------------------------------------------------------
  // avalon slave: one wait state on every access
  // ----------------------------------------------------------------
  // status: state, remaining beats, unmasked wait pin seen, reserved code stored
  wire [31:0] stat_val = {16'h0, 8'(beats_left), 2'h0, w_rsvd, honour, state};
  wire [31:0] rd_mux   = sel_ctrl ? ctrl_val : (sel_stat ? stat_val : 32'h0);

  // unmapped words read zero and swallow writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0;
    end else if (ce) begin
      waitrequest <= !((read || write) && waitrequest);
      if (read && waitrequest) readdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  first_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    ce && start_ok |=> wif.remain == brw_pkg::brw_first_wait($past(w_code)))
    else $error("first access wait count wrong");
  gap_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    ce && gap_go |=> state == brw_pkg::BRW_GAP && wif.remain == {3'h0, $past(bw_code)} - 5'h01)
    else $error("burst wait count wrong");
  zero_gap_a: assert property (@(posedge clk) disable iff (!arst_n)
    ce && beat_take && !last_beat && bw_code == 2'h0 |=> state == brw_pkg::BRW_BEAT)
    else $error("zero burst wait inserted a cycle");
  mask_ignores_a: assert property (@(posedge clk) disable iff (!arst_n)
    ce && ext_wait_mask && state == brw_pkg::BRW_FIRST && tick && wif.remain == '0
    |=> state == brw_pkg::BRW_BEAT) else $error("masked wait pin stretched access");
  wait_holds_a: assert property (@(posedge clk) disable iff (!arst_n)
    ce && !ext_wait_mask && !wait_s2 && state == brw_pkg::BRW_FIRST
    |=> state == brw_pkg::BRW_FIRST) else $error("honoured wait did not hold access");
  rsvd_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
    read && !waitrequest && sel_ctrl |-> (readdata & ~`BRW_CTRL_MASK) == 32'h0)
    else $error("reserved bits read nonzero");
  bus_answer_a: assert property (@(posedge clk) disable iff (!arst_n)
    ce && (read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer not within one cycle");
  burst_done_c: cover property (@(posedge clk) disable iff (!arst_n)
    start_ok && acc_len > LEN_W'(2) ##[1:400] acc_done);
  held_zero_wait_c: cover property (@(posedge clk) disable iff (!arst_n)
    state == brw_pkg::BRW_FIRST && w_code == 4'h0 && honour);
  rsvd_code_c: cover property (@(posedge clk) disable iff (!arst_n) w_rsvd);
endmodule : brw_top

/* rtl/brw_waitgen.sv */
/*
  wait cycle counter: loads a count, steps down once per rom clock
  edge and reports done when empty and not held by the wait pin.
  assumes tick and hold already synchronised to clk.
*/
`timescale 1ns/10ps
module brw_waitgen (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // sequencer side
  brw_wait_if.cnt   w
);
  brw_pkg::brw_cnt_t remain;  // cycles left

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire empty = (remain == '0);
  assign w.remain = remain;
  // a held pin stretches the cycle only after the count ran out
  assign w.done   = w.tick && empty && !w.hold && !w.load;

  // counter, steps only on rom clock edges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      remain <= '0;
    end else if (w.ce) begin
      if (w.load) begin
        remain <= w.load_val;
      end else if (w.tick && !empty) begin
        remain <= remain - 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // a held empty counter must not wrap while the pin stretches the cycle
  hold_keeps_empty_a: assert property (@(posedge clk) disable iff (!arst_n)
    w.ce && w.hold && empty && !w.load |=> remain == '0)
    else $error("held wait counter left zero");
  count_steps_a: assert property (@(posedge clk) disable iff (!arst_n)
    w.ce && w.tick && !w.load && !empty |=> remain == $past(remain) - 5'h01)
    else $error("wait counter did not step on tick");
  held_zero_c: cover property (@(posedge clk) disable iff (!arst_n)
    w.tick && empty && w.hold ##[1:1000] w.done);
endmodule : brw_waitgen

/* tb/brw_rom_model.sv */
/*
  behavioural burst rom on the far side of the wait controller.
  assumes the bench sets hold and base before chip select falls.
*/
`timescale 1ns/10ps
module brw_rom_model (
  // bench side
  input  wire logic        clk,
  input  wire logic [4:0]  hold,
  input  wire logic [15:0] base,
  output int               edges,
  // rom pins
  input  wire logic        rom_cs_n,
  output logic             rom_clk,
  output logic             rom_wait_n,
  output logic [15:0]      rom_data
);
  initial begin
    rom_clk = 1'b0;
    rom_wait_n = 1'b1;
    rom_data = 16'hA5A5;
    edges = 0;
  end
  // clock runs only inside a frame; data and wait move on its falling edge
  // edges sit 5 ns off the clk edges so the synchronisers never race them
  always begin
    wait (rom_cs_n === 1'b0);
    #195 rom_clk = 1'b1;
    edges = edges + 1;
    #200 rom_clk = 1'b0;
    rom_data = base ^ {edges[7:0], ~edges[7:0]};
    rom_wait_n = (edges >= hold);
    #5;
  end
  // frame start: first word out, wait pin held for hold edges
  always @(negedge rom_cs_n) begin
    edges = 0;
    rom_data = base ^ 16'h00FF;
    rom_wait_n = (hold == 5'h00);
  end
  // deselected: pulled-up wait, data toggles so a stale capture shows
  // falling clk edge, so it never fights the frame start above
  always @(negedge clk) begin
    if (rom_cs_n === 1'b1) begin
      rom_data = ~rom_data;
      rom_wait_n = 1'b1;
    end
  end
endmodule : brw_rom_model

/* tb/tb.sv */
/*
  self-checking bench of the burst rom wait controller.
  assumes brw_top and brw_rom_model compiled before it.
*/
`timescale 1ns/10ps
module tb;
  // ------------------------------------------------------------
  // signals and design
  // ------------------------------------------------------------
  logic        clk = 1'b0, arst_n = 1'b0, read = 1'b0, write = 1'b0, acc_start = 1'b0;
  logic [3:0]  address = 4'h0, byteenable = 4'h0, acc_len = 4'h0;
  logic [31:0] writedata = 32'h0, readdata;
  logic        waitrequest, acc_busy, acc_done, beat_valid;
  logic        rom_clk, rom_wait_n, rom_cs_n, rom_oe_n;
  logic [15:0] beat_data, rom_data, base = 16'h0;
  logic [4:0]  hold = 5'h00;
  int          edges, e, num_errors = 0, n_tests = 0;
  logic        last_exp;    // expected last-beat flag
  int          q_edge[$];   // expected rom edge of each beat
  logic        q_last[$];   // expected done flag of each beat
  logic [31:0] q_rd[$];     // expected read words
  always #25 clk = ~clk;
  brw_top uut (.clk, .arst_n, .ce(1'b1), .address, .read, .write, .byteenable, .writedata,
    .readdata, .waitrequest, .acc_start, .acc_len, .acc_busy, .acc_done, .beat_valid,
    .beat_data, .rom_clk, .rom_wait_n, .rom_data, .rom_cs_n, .rom_oe_n);
  brw_rom_model rom (.clk, .hold, .base, .edges, .rom_cs_n, .rom_clk, .rom_wait_n, .rom_data);
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    int k;
    k = 0;
    @(posedge clk);
    {read, write, address, writedata, byteenable} <= {~w, w, a, d, b};
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    if (k >= 50) begin
      chk(32'h0, 32'h1);
      finish_test;
    end
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    q_rd.push_back(x);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask : rd
  function automatic int wcyc(input logic [3:0] c);
    case (c)
      4'h7: return 8;
      4'h8: return 10;
      4'h9: return 12;
      4'hA: return 14;
      4'hB: return 18;
      4'hC: return 24;
      default: return int'(c);
    endcase
  endfunction : wcyc
  // program, then run one burst and note when each beat must land
  task automatic acc(input logic [3:0] c, input logic [1:0] bw, input logic wm,
                     input logic [4:0] h, input logic [3:0] len);
    logic [31:0] v;
    int          f, k;
    v = {14'h0, bw, 5'h0, c, wm, 6'h0};
    bus(1'b1, 4'h0, v, 4'hF);
    rd(4'h0, v);
    f = wcyc(c);
    if (!wm && h > f) f = h;
    for (k = 0; k < len; k++) begin
      q_edge.push_back(f + 2 + k * (bw + 1));
      q_last.push_back(k == len - 1);
    end
    hold <= h;
    base <= 16'($urandom);
    @(posedge clk);
    acc_start <= 1'b1;
    acc_len <= len;
    @(posedge clk);
    acc_start <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (acc_busy !== 1'b0 && k < 3000);
    if (k >= 3000) begin
      chk(32'h0, 32'h1);
      finish_test;
    end
    // let the watcher take the last beat before the queue is looked at
    @(posedge clk);
    chk(32'(q_edge.size()), 32'h0);
  endtask : acc
  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  // ------------------------------------------------------------
  // result watcher: oldest note against each answer
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (read && waitrequest === 1'b0) chk(readdata, q_rd.size() ? q_rd.pop_front() : 32'hX);
    if (beat_valid === 1'b1) begin
      e = q_edge.size() ? q_edge.pop_front() : -1;
      last_exp = q_last.size() ? q_last.pop_front() : 1'bX;
      chk(edges, e);
      chk(beat_data, base ^ {8'(e - 1), ~8'(e - 1)});
      chk(acc_done, last_exp);
      chk({rom_cs_n, rom_oe_n}, {2{last_exp}});
    end
  end
  // hang guard, well above the longest sequence
  initial begin
    #2000000;
    num_errors++;
    finish_test;
  end
  initial begin
    int         i;
    logic [3:0] c;
    void'($urandom(53));
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(4'h0, 32'h0000_0500);
    rd(4'h5, 32'h0);
    rd(4'h1, 32'h0000_0001);
    bus(1'b1, 4'h0, 32'h0003_07C0, 4'h1);
    rd(4'h0, 32'h0000_05C0);
    bus(1'b1, 4'h9, 32'hFFFF_FFFF, 4'hF);
    rd(4'h0, 32'h0000_05C0);
    // zero-length start must be ignored
    @(posedge clk);
    acc_start <= 1'b1;
    @(posedge clk);
    acc_start <= 1'b0;
    @(posedge clk);
    chk(acc_busy, 32'h0);
    for (i = 0; i < 16; i++) begin
      c = (i < 13) ? 4'(i) : 4'h0;
      acc(c, 2'($urandom), i[0], (i == 14) ? 5'h14 : 5'($urandom % 8), 4'(1 + $urandom % 3));
    end
    finish_test;
  end
endmodule : tb
